// ---- include/lfp_pkg.sv ----
// Constants and carrier types for the LED driver fault protection block
package lfp_pkg;
  localparam int CLK_MHZ = 250;
  localparam int BLANK_NS = 50;
  localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int SHORT_QUAL_NS = 1000;
  localparam int SHORT_QUAL_CYC = (SHORT_QUAL_NS * CLK_MHZ + 999) / 1000;
  localparam int RETRY_WIN_US = 20;
  localparam int RETRY_WIN_CYC = RETRY_WIN_US * CLK_MHZ;
  localparam int STARTUP_US = 300;
  localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;
  localparam int STARTUP_SW_CYC = 64;
  localparam int HICCUP_SW_CYC = 8192;
  localparam int BB_SHORT_SW_CYC = 8192;
  localparam int TW = 17;
  localparam logic [TW-1:0] T_ZERO = 17'h0_0000;
  localparam logic [TW-1:0] T_ONE = 17'h0_0001;

  // Qualified comparator indications from the analog front end
  typedef struct packed {
    logic over_volt;
    logic over_temp;
    logic boost_short;
    logic bb_short;
    logic cs_trip;
  } lfp_sense_t;

  // Gate and flag drive bundle
  typedef struct packed {
    logic gate;
    logic dim_n;
    logic comp_conn;
    logic flt_oe;
  } lfp_drive_t;
endpackage

// ---- verilog/lfp_core.sv ----
// LED driver protection, hiccup and fault sequencing core
`timescale 1ns/1ps
module lfp_core #(
  parameter int STARTUP_CYCLES = lfp_pkg::STARTUP_CYC, // Startup delay in core clocks
  parameter int RETRY_CYCLES = lfp_pkg::RETRY_WIN_CYC, // Retry window in core clocks
  parameter int HICCUP_CYCLES = lfp_pkg::HICCUP_SW_CYC, // Hiccup length, switch cycles
  parameter int BB_CYCLES = lfp_pkg::BB_SHORT_SW_CYC // Buck-boost count limit
) (
  input wire logic core_clk, // 250 MHz clock
  input wire logic rst, // Async reset, active high
  input wire logic sw_tick, // One-cycle pulse at each switching cycle start
  input wire logic supply_lockout, // High while supply is below threshold
  input wire logic pulse_dim_input, // Dimming pin level
  input wire lfp_pkg::lfp_sense_t sense, // Comparator indications (pins)
  output logic switch_gate_drive, // Switch gate enable
  output logic dim_gate_out_n, // Dim gate, high turns dim FET off
  output logic comp_connect, // Error amp to compensation switch
  output logic fault_flag_n_out, // Fault flag pin output (always 0)
  output logic fault_flag_n_oe // Fault flag pull-down enable
);
  import lfp_pkg::*;

  typedef enum logic [1:0] {ST_START, ST_RUN, ST_HICCUP, ST_RETRY} lfp_state_t;

  lfp_state_t state;
  logic [TW-1:0] tmr;
  logic [TW-1:0] sw_cnt;
  logic [TW-1:0] qual_cnt;
  logic [TW-1:0] blank_cnt;
  logic [TW-1:0] bb_cnt;
  logic [4:0] s1, s2, s3, sq;
  logic [1:0] d1, d2, d3;
  logic dim_q, supply_lockout_q;
  logic bb_flag, retry_flag, on_pulse;
  logic prot, short_qual, blanked;

  // Three-stage sync; a change counts when stages two and three agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1 <= 5'h00;
      s2 <= 5'h00;
      s3 <= 5'h00;
      d1 <= 2'h3;
      d2 <= 2'h3;
      d3 <= 2'h3;
    end else begin
      s1 <= sense;
      s2 <= s1;
      s3 <= s2;
      d1 <= {pulse_dim_input, supply_lockout};
      d2 <= d1;
      d3 <= d2;
    end
  end

  // Qualified levels
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sq <= 5'h00;
      dim_q <= 1'b1;
      supply_lockout_q <= 1'b1;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (s2[i] == s3[i]) sq[i] <= s3[i];
      end
      if (d2[1] == d3[1]) dim_q <= d3[1];
      if (d2[0] == d3[0]) supply_lockout_q <= d3[0];
    end
  end

  // Field views of the qualified sense vector
  logic ov, ot, bst, bbs, cst;
  assign ov = sq[4];
  assign ot = sq[3];
  assign bst = sq[2];
  assign bbs = sq[1];
  assign cst = sq[0];

  // Boost short must persist one microsecond
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) qual_cnt <= T_ZERO;
    else if (!bst || state == ST_HICCUP) qual_cnt <= T_ZERO;
    else if (qual_cnt < TW'(SHORT_QUAL_CYC)) qual_cnt <= qual_cnt + T_ONE;
  end
  assign short_qual = (qual_cnt >= TW'(SHORT_QUAL_CYC));

  // Startup, hiccup and retry sequencing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_START;
      tmr <= T_ZERO;
      sw_cnt <= T_ZERO;
      retry_flag <= 1'b0;
    end else if (supply_lockout_q) begin
      state <= ST_START;
      tmr <= T_ZERO;
      sw_cnt <= T_ZERO;
      retry_flag <= 1'b0;
    end else begin
      case (state)
        ST_START: begin
          if (tmr < TW'(STARTUP_CYCLES)) tmr <= tmr + T_ONE;
          else if (sw_tick) sw_cnt <= sw_cnt + T_ONE;
          if (sw_tick && tmr >= TW'(STARTUP_CYCLES) &&
              sw_cnt == TW'(STARTUP_SW_CYC - 1)) begin
            state <= ST_RUN;
            sw_cnt <= T_ZERO;
          end
        end
        ST_RUN: begin
          if (short_qual) begin
            state <= ST_HICCUP;
            sw_cnt <= T_ZERO;
            retry_flag <= 1'b1;
          end
        end
        ST_HICCUP: begin
          if (sw_tick) sw_cnt <= sw_cnt + T_ONE;
          if (sw_tick && sw_cnt == TW'(HICCUP_CYCLES - 1)) begin
            state <= ST_RETRY;
            tmr <= T_ZERO;
          end
        end
        ST_RETRY: begin
          if (short_qual) begin
            state <= ST_HICCUP;
            sw_cnt <= T_ZERO;
          end else if (tmr == TW'(RETRY_CYCLES - 1)) begin
            state <= ST_RUN;
            retry_flag <= 1'b0;
          end else begin
            tmr <= tmr + T_ONE;
          end
        end
        default: state <= ST_START;
      endcase
    end
  end

  // Buck-boost up/down counter, saturating, with hysteretic flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bb_cnt <= T_ZERO;
      bb_flag <= 1'b0;
    end else if (sw_tick) begin
      if (bbs) begin
        if (bb_cnt < TW'(BB_CYCLES)) bb_cnt <= bb_cnt + T_ONE;
        if (bb_cnt == TW'(BB_CYCLES - 1)) bb_flag <= 1'b1;
      end else begin
        if (bb_cnt > T_ZERO) bb_cnt <= bb_cnt - T_ONE;
        if (bb_cnt == T_ONE) bb_flag <= 1'b0;
      end
    end
  end

  // Overvoltage, overtemperature and any state other than run or retry override dimming
  assign prot = ov | ot | (state != ST_RUN && state != ST_RETRY);

  // Leading-edge blanking counter restarts each switching cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) blank_cnt <= T_ZERO;
    else if (sw_tick) blank_cnt <= T_ZERO;
    else if (blank_cnt < TW'(BLANK_CYC)) blank_cnt <= blank_cnt + T_ONE;
  end
  assign blanked = (blank_cnt < TW'(BLANK_CYC));

  // On-pulse: set at cycle start, ended by unblanked current trip
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) on_pulse <= 1'b0;
    else if (sw_tick) on_pulse <= 1'b1;
    else if (cst && !blanked) on_pulse <= 1'b0;
  end

  // Registered pin drive; protection wins over the dim input
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      switch_gate_drive <= 1'b0;
      dim_gate_out_n <= 1'b1;
      comp_connect <= 1'b0;
    end else begin
      switch_gate_drive <= !prot && dim_q && on_pulse && !(cst && !blanked);
      dim_gate_out_n <= prot || !dim_q;
      comp_connect <= !prot && dim_q;
    end
  end

  // Open-drain flag: pull-down enable only, output level fixed low
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fault_flag_n_oe <= 1'b0;
      fault_flag_n_out <= 1'b0;
    end else begin
      fault_flag_n_oe <= ov | ot | bb_flag | retry_flag;
      fault_flag_n_out <= 1'b0;
    end
  end

  AST_OV_GATE: assert property (@(posedge core_clk) disable iff (rst)
    ov |=> !switch_gate_drive && dim_gate_out_n && fault_flag_n_oe)
    else $error("overvoltage did not force outputs");
  AST_OV_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
    $fell(ov) && state == ST_RUN && dim_q && !ot && !bb_flag ##1 !supply_lockout_q
      |-> !dim_gate_out_n && !fault_flag_n_oe)
    else $error("overvoltage clear not released");
  AST_OT: assert property (@(posedge core_clk) disable iff (rst)
    ot |=> !switch_gate_drive && dim_gate_out_n && fault_flag_n_oe)
    else $error("overtemperature did not force outputs");
  AST_HICCUP: assert property (@(posedge core_clk) disable iff (rst)
    state == ST_HICCUP |=> !switch_gate_drive && !comp_connect && fault_flag_n_oe)
    else $error("hiccup outputs wrong");
  AST_HICCUP_START: assert property (@(posedge core_clk) disable iff (rst || supply_lockout_q)
    state == ST_RUN && short_qual |=> state == ST_HICCUP)
    else $error("hiccup not started");
  AST_RETRY_LATCH: assert property (@(posedge core_clk) disable iff (rst)
    state == ST_RETRY |=> fault_flag_n_oe)
    else $error("flag not latched in retry");
  AST_BB_COUNT: assert property (@(posedge core_clk) disable iff (rst)
    bb_cnt <= TW'(BB_CYCLES))
    else $error("buck-boost counter overrun");
  AST_BB_FLAG: assert property (@(posedge core_clk) disable iff (rst)
    $rose(bb_flag) |-> bb_cnt == TW'(BB_CYCLES))
    else $error("buck-boost flag early");
  // Checked one cycle at a time, so the blanking length stays a package constant
  AST_BLANK: assert property (@(posedge core_clk) disable iff (rst)
    blanked && on_pulse && !sw_tick |=> on_pulse)
    else $error("on-pulse ended inside blanking");
  AST_DIM: assert property (@(posedge core_clk) disable iff (rst)
    !dim_q |=> !switch_gate_drive && dim_gate_out_n && !comp_connect)
    else $error("dim low did not disable");

  COV_HICCUP: cover property (@(posedge core_clk) state == ST_HICCUP ##1 state == ST_RETRY);
  COV_RETRY_OK: cover property (@(posedge core_clk) state == ST_RETRY ##1 state == ST_RUN);
  COV_REENTRY: cover property (@(posedge core_clk) state == ST_RETRY ##1 state == ST_HICCUP);
  COV_BB: cover property (@(posedge core_clk) $rose(bb_flag));
  COV_TRIP: cover property (@(posedge core_clk) $fell(on_pulse) && !sw_tick);
endmodule

// ---- test/lfp_plant.sv ----
// Far-side model: switching oscillator and switch current-sense comparator
`timescale 1ns/1ps
module lfp_plant (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Async reset, active high
  input wire logic gate, // Switch gate drive from the block
  input wire logic [4:0] trip_at, // Phase at which switch current hits peak
  output logic sw_tick, // Switching cycle start pulse
  output logic cs_trip, // Peak current comparator output
  output logic [4:0] phase // Position within the 32-clock switching cycle
);
  logic ramp_on;
  // Free-running oscillator, 32 core clocks per switching cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) phase <= 5'h00;
    else phase <= phase + 5'h01;
  end
  // Inductor current only ramps once the switch has been turned on
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) ramp_on <= 1'b0;
    else if (sw_tick) ramp_on <= 1'b0;
    else if (gate) ramp_on <= 1'b1;
  end
  assign sw_tick = (phase == 5'h00);
  // Comparator stays tripped until the cycle ends, like a real ramp past peak
  assign cs_trip = ramp_on && (phase >= trip_at);
endmodule

// ---- test/tb_led_driver_fault_protection.sv ----
// Self-checking bench for the LED driver protection core
`timescale 1ns/1ps
module tb_led_driver_fault_protection;
  import lfp_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic supply_lockout = 1'b1;
  logic pulse_dim_input = 1'b1;
  logic ov = 1'b0, ot = 1'b0, bs = 1'b0, bb = 1'b0;
  logic [4:0] trip_at = 5'h14;
  logic sw_tick, cs_trip, gate, dim_n, comp, flt_out, flt_oe;
  logic [4:0] phase;
  lfp_sense_t sense;
  int miscompares = 0, n_compared = 0, cycles = 0;
  // Board pull-up on the open-drain flag
  wire flag_pin = flt_oe ? flt_out : 1'b1;
  assign sense = '{over_volt: ov, over_temp: ot, boost_short: bs, bb_short: bb, cs_trip: cs_trip};

  // Retry window longer than the 1us short qualification, so re-entry can happen
  lfp_core #(.STARTUP_CYCLES(20), .RETRY_CYCLES(300), .HICCUP_CYCLES(8), .BB_CYCLES(8)) dut_u (
    .core_clk(core_clk), .rst(rst), .sw_tick(sw_tick), .supply_lockout(supply_lockout),
    .pulse_dim_input(pulse_dim_input), .sense(sense), .switch_gate_drive(gate),
    .dim_gate_out_n(dim_n), .comp_connect(comp), .fault_flag_n_out(flt_out),
    .fault_flag_n_oe(flt_oe));
  lfp_plant plant_u (.core_clk(core_clk), .rst(rst), .gate(gate), .trip_at(trip_at),
    .sw_tick(sw_tick), .cs_trip(cs_trip), .phase(phase));

  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // Hang guard: whole run needs about 8k clocks
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic final_report();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic seen, input logic exp, input string m);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s: saw %b expected %b", $time, m, seen, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge core_clk iff sw_tick);
  endtask
  task automatic ph(input logic [4:0] p);
    @(posedge core_clk iff phase == p);
    #1;
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Switching mid-cycle with no fault present
  task automatic run_ok();
    ph(5'h0a);
    chk(gate, 1'b1, "gate on");
    chk(dim_n, 1'b0, "dim fet on");
    chk(comp, 1'b1, "amp connected");
    chk(flag_pin, 1'b1, "flag idle");
  endtask
  task automatic off_chk(input logic flag);
    chk(gate, 1'b0, "gate off");
    chk(dim_n, 1'b1, "dim fet off");
    chk(flag_pin, flag, "flag level");
  endtask

  task automatic t_startup();
    tk(60);
    ph(5'h0a);
    chk(gate, 1'b0, "gate before startup end");
    tk(10);
    run_ok();
  endtask
  task automatic t_pulse();
    ph(5'h1e);
    chk(gate, 1'b0, "on-pulse ended by trip");
    @(posedge core_clk);
    trip_at <= 5'h02;
    tk(1);
    ph(5'h0a);
    chk(gate, 1'b1, "early trip blanked");
    ph(5'h14);
    chk(gate, 1'b0, "trip after blanking");
    @(posedge core_clk);
    trip_at <= 5'h14;
    tk(1);
  endtask
  task automatic t_ov_ot(input bit temp);
    @(posedge core_clk);
    if (temp) ot <= 1'b1;
    else ov <= 1'b1;
    clk(8);
    off_chk(1'b0);
    @(posedge core_clk);
    ot <= 1'b0;
    ov <= 1'b0;
    clk(8);
    chk(flag_pin, 1'b1, "flag released");
    run_ok();
  endtask
  task automatic t_dim();
    @(posedge core_clk);
    pulse_dim_input <= 1'b0;
    clk(8);
    off_chk(1'b1);
    chk(comp, 1'b0, "amp held off");
    @(posedge core_clk);
    ov <= 1'b1;
    clk(8);
    off_chk(1'b0);
    @(posedge core_clk);
    ov <= 1'b0;
    pulse_dim_input <= 1'b1;
    clk(8);
    run_ok();
  endtask
  task automatic t_hiccup();
    @(posedge core_clk);
    bs <= 1'b1;
    clk(300);
    off_chk(1'b0);
    chk(comp, 1'b0, "amp off in hiccup");
    @(posedge core_clk);
    bs <= 1'b0;
    tk(4);
    clk(2);
    off_chk(1'b0);
    tk(4);
    clk(2);
    chk(gate, 1'b1, "retry switching");
    chk(flag_pin, 1'b0, "flag latched in retry");
    tk(12);
    run_ok();
  endtask
  // Short still present in the retry window sends the block back to hiccup
  task automatic t_retry();
    @(posedge core_clk);
    bs <= 1'b1;
    clk(300);
    off_chk(1'b0);
    tk(20);
    clk(1);
    chk(flag_pin, 1'b0, "flag held, short seen in retry");
    @(posedge core_clk);
    bs <= 1'b0;
    tk(20);
    run_ok();
  endtask
  task automatic t_bb();
    tk(1);
    bb <= 1'b1;
    tk(5);
    run_ok();
    tk(5);
    clk(2);
    chk(flag_pin, 1'b0, "count limit flag");
    @(posedge core_clk);
    bb <= 1'b0;
    tk(5);
    clk(2);
    chk(flag_pin, 1'b0, "flag held while counting down");
    tk(5);
    run_ok();
  endtask

  // Supply dip in mid-run restarts the whole startup sequence
  task automatic t_lockout();
    @(posedge core_clk);
    supply_lockout <= 1'b1;
    clk(8);
    off_chk(1'b1);
    chk(comp, 1'b0, "amp off in lockout");
    @(posedge core_clk);
    supply_lockout <= 1'b0;
    t_startup();
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    supply_lockout <= 1'b0;
    t_startup();
    t_pulse();
    t_ov_ot(1'b0);
    t_ov_ot(1'b1);
    t_dim();
    t_hiccup();
    t_retry();
    t_bb();
    t_lockout();
    final_report();
  end
endmodule
